// *** hw/frsel_pkg.sv ***
// constants for the fault response select register bank
// assumes byte-wide command-code register access and a 25 MHz core clock
package frsel_pkg;

    // command codes (register addresses)
    localparam logic [7:0] ADDR_INDIV_EN   = 8'hB0;
    localparam logic [7:0] ADDR_FLYBACK    = 8'hB4;
    localparam logic [7:0] ADDR_OC_PHASE   = 8'hB6;
    localparam logic [7:0] ADDR_BUS_VOLT   = 8'hB7;
    localparam logic [7:0] ADDR_PHASE_DIS  = 8'hBC;
    localparam logic [7:0] ADDR_ST_CURRENT = 8'hD5;
    localparam logic [7:0] ADDR_ST_BUSV    = 8'hD7;
    localparam logic [7:0] ADDR_ST_FLYBACK = 8'hD8;
    localparam logic [7:0] ADDR_ST_PHASE   = 8'hDA;

    // field positions
    localparam int INDIV_EN_BIT     = 7;
    localparam int FET_SHORT_BIT    = 7;
    localparam int OC2_RESP_LSB     = 6;
    localparam int PH_REMOVE_BIT    = 5;
    localparam int OUT_OV_LSB       = 0;
    localparam int OUT_UV_LSB       = 2;
    localparam int IN_OV_LSB        = 4;
    localparam int IN_UV_LSB        = 6;
    localparam int ST_OC2_BIT       = 1;
    localparam int ST_OUT_OV_BIT    = 0;
    localparam int ST_FET_SHORT_BIT = 4;

    // writable bits of the overcurrent/phase register, bits 2:0 reserved
    localparam logic [7:0] OC_PHASE_MASK = 8'hF8;
    localparam logic [7:0] REG_RESET     = 8'h00;

    // two-bit response codes
    localparam logic [1:0] RESP_FLAG   = 2'h0;
    localparam logic [1:0] RESP_HICCUP = 2'h1;
    localparam logic [1:0] RESP_LATCH  = 2'h2;

    // auto-restart delay
    localparam int CLK_HZ          = 25_000_000;
    localparam int RESTART_TIME_MS = 500;
    localparam int RESTART_CYCLES  = RESTART_TIME_MS * (CLK_HZ / 1000);

    localparam int NUM_PHASES = 4;

endpackage : frsel_pkg

// *** hw/frsel_restart_timer.sv ***
// hiccup / latch-off switching stop for one fault source
// assumes fault is already synchronised; release is a one-cycle pulse
`timescale 1ns/1ps
module frsel_restart_timer
    import frsel_pkg::*;
#(
    parameter int RESTART = RESTART_CYCLES
)(
    input  wire logic sys_clk,
    input  wire logic rst_n,
    input  wire logic clk_en,
    input  wire logic fault,
    input  wire logic hiccup,
    input  wire logic latch,
    input  wire logic release_in,
    output logic      stop
);
    localparam int CW = $clog2(RESTART + 1);
    localparam logic [CW-1:0] LAST = CW'(RESTART - 1);

    typedef enum logic [1:0] {RUN, HOLD, LATCHED} frsel_tmr_state_t;

    typedef struct packed {
        frsel_tmr_state_t state;
        logic [CW-1:0]    cnt;
        logic             stop;
    } frsel_tmr_t;

    frsel_tmr_t r;
    frsel_tmr_t n;

    always_comb
    begin
        n = r;
        case (r.state)
            RUN:
            begin
                n.cnt = '0;
                if (fault && latch)
                    n.state = LATCHED;
                else if (fault && hiccup)
                    n.state = HOLD;
            end
            HOLD:
            begin
                // delay counts only once the condition has gone away
                if (fault)
                    n.cnt = '0;
                else if (r.cnt == LAST)
                    n.state = RUN;
                else
                    n.cnt = r.cnt + CW'(1);
            end
            LATCHED:
            begin
                // no self recovery; only an enable toggle restarts
                if (release_in)
                    n.state = RUN;
            end
            default:
                n.state = RUN;
        endcase
        n.stop = (n.state != RUN);
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            r <= '0;
            r.state <= RUN;
        end
        else if (clk_en)
            r <= n;
    end

    assign stop = r.stop;

endmodule : frsel_restart_timer

// *** hw/frsel_top.sv ***
// fault response select: response registers, sticky status and stop controls
// assumes detector inputs, enables and strap come from pins (synchronised here)
// and that registers are reached by byte command codes on one clock
`timescale 1ns/1ps
module frsel_top
    import frsel_pkg::*;
#(
    parameter int RESTART = RESTART_CYCLES,
    parameter int PHASES  = NUM_PHASES
)(
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    input  wire logic        clk_en,
    input  wire logic        reg_wr_en,
    input  wire logic        reg_rd_en,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    output logic      [7:0]  reg_rdata,
    input  wire logic        fet_short_det,
    input  wire logic [3:0]  oc2_det,
    input  wire logic        lvb_out_ov_det,
    input  wire logic        en_in,
    input  wire logic        pwm_en_in,
    input  wire logic [1:0]  strap_resp,
    output logic             fault_flag_n_out,
    output logic             fault_flag_n_oe_n,
    output logic             system_fail_n_out,
    output logic             system_fail_n_oe_n,
    output logic             pwm_stop,
    output logic             flyback_stop
);
    typedef struct packed {
        logic [1:0] strap_s1;
        logic [1:0] strap_s2;
        logic       fet_s1;
        logic       fet_s2;
        logic [3:0] oc2_s1;
        logic [3:0] oc2_s2;
        logic       ov_s1;
        logic       ov_s2;
        logic       en_s1;
        logic       en_s2;
        logic       en_d;
        logic       pwmen_s1;
        logic       pwmen_s2;
        logic       pwmen_d;
        logic [7:0] indiv;
        logic [7:0] flyback;
        logic [7:0] oc_phase;
        logic [7:0] bus_volt;
        logic [7:0] phase_dis;
        logic       st_fet;
        logic       st_oc2;
        logic       st_ov;
        logic [3:0] st_phase;
        logic       sys_latch;
        logic       od_level;
        logic       flag_oe_n;
        logic       fail_oe_n;
        logic       pwm_stop;
        logic       fly_stop;
        logic [7:0] rdata;
    } frsel_state_t;

    frsel_state_t r;
    frsel_state_t n;

    logic       oc_stop;
    logic       ov_stop;
    logic       en_rise;
    logic       release_pwm;
    logic [1:0] oc2_resp;
    logic [1:0] ov_resp;
    logic       short_flag_only;
    logic       oc2_any;
    logic       ph_fault;
    logic       oc_cond;
    logic [3:0] ph_count;
    logic       wr_st_cur;
    logic       wr_st_busv;
    logic       wr_st_fly;
    logic       wr_st_ph;

    always_comb
    begin
        n = r;
        // two-stage synchronisers; first stage feeds only the second
        n.strap_s1 = strap_resp;
        n.strap_s2 = r.strap_s1;
        n.fet_s1   = fet_short_det;
        n.fet_s2   = r.fet_s1;
        n.oc2_s1   = oc2_det;
        n.oc2_s2   = r.oc2_s1;
        n.ov_s1    = lvb_out_ov_det;
        n.ov_s2    = r.ov_s1;
        n.en_s1    = en_in;
        n.en_s2    = r.en_s1;
        n.en_d     = r.en_s2;
        n.pwmen_s1 = pwm_en_in;
        n.pwmen_s2 = r.pwmen_s1;
        n.pwmen_d  = r.pwmen_s2;

        en_rise     = r.en_s2 & ~r.en_d;
        release_pwm = en_rise | (r.pwmen_s2 & ~r.pwmen_d);

        oc2_resp        = r.indiv[INDIV_EN_BIT] ? r.oc_phase[OC2_RESP_LSB +: 2] : r.strap_s2;
        ov_resp         = r.indiv[INDIV_EN_BIT] ? r.bus_volt[OUT_OV_LSB +: 2] : r.strap_s2;
        short_flag_only = r.indiv[INDIV_EN_BIT] ? r.flyback[FET_SHORT_BIT] : 1'b0;

        oc2_any  = |r.oc2_s2;
        ph_count = 4'h0;
        for (int i = 0; i < 4; i++)
            ph_count = ph_count + {3'h0, r.phase_dis[i]};
        // more than half disabled joins the overcurrent response
        ph_fault = r.oc_phase[PH_REMOVE_BIT] && (ph_count > 4'(PHASES / 2));
        oc_cond  = oc2_any | ph_fault;

        wr_st_cur  = reg_wr_en && (reg_addr == ADDR_ST_CURRENT);
        wr_st_busv = reg_wr_en && (reg_addr == ADDR_ST_BUSV);
        wr_st_fly  = reg_wr_en && (reg_addr == ADDR_ST_FLYBACK);
        wr_st_ph   = reg_wr_en && (reg_addr == ADDR_ST_PHASE);

        if (reg_wr_en)
        begin
            case (reg_addr)
                ADDR_INDIV_EN:  n.indiv     = reg_wdata;
                ADDR_FLYBACK:   n.flyback   = reg_wdata;
                ADDR_OC_PHASE:  n.oc_phase  = reg_wdata & OC_PHASE_MASK;
                ADDR_BUS_VOLT:  n.bus_volt  = reg_wdata;
                ADDR_PHASE_DIS: n.phase_dis = reg_wdata;
                default:        n.indiv     = r.indiv;
            endcase
        end

        // sticky, write-one clears, a new event wins over the clear
        n.st_fet = r.fet_s2 | (r.st_fet & ~(wr_st_fly & reg_wdata[ST_FET_SHORT_BIT]));
        // overcurrent only flags at this point
        n.st_oc2 = oc2_any | (r.st_oc2 & ~(wr_st_cur & reg_wdata[ST_OC2_BIT]));
        n.st_ov  = r.ov_s2 | (r.st_ov & ~(wr_st_busv & reg_wdata[ST_OUT_OV_BIT]));
        n.st_phase = r.oc2_s2 | (r.st_phase & ~({4{wr_st_ph}} & reg_wdata[3:0]));

        // short latches the system off until EN rises
        // flag-only setting never touches the fail line
        n.sys_latch = (r.fet_s2 & ~short_flag_only) | (r.sys_latch & ~en_rise);

        // flag follows any standing status bit
        n.flag_oe_n = ~(n.st_fet | n.st_oc2 | n.st_ov | (|n.st_phase));
        n.fail_oe_n = ~n.sys_latch;
        n.fly_stop  = n.sys_latch;
        n.pwm_stop  = n.sys_latch | oc_stop | ov_stop;
        n.od_level  = 1'b0;

        if (reg_rd_en)
        begin
            case (reg_addr)
                ADDR_INDIV_EN:   n.rdata = r.indiv;
                ADDR_FLYBACK:    n.rdata = r.flyback;
                ADDR_OC_PHASE:   n.rdata = r.oc_phase;
                ADDR_BUS_VOLT:   n.rdata = r.bus_volt;
                ADDR_PHASE_DIS:  n.rdata = r.phase_dis;
                ADDR_ST_CURRENT: n.rdata = {6'h00, r.st_oc2, 1'b0};
                ADDR_ST_BUSV:    n.rdata = {7'h00, r.st_ov};
                ADDR_ST_FLYBACK: n.rdata = {3'h0, r.st_fet, 4'h0};
                ADDR_ST_PHASE:   n.rdata = {4'h0, r.st_phase};
                default:         n.rdata = 8'h00;
            endcase
        end
    end

    // hiccup restart or latch-off for overcurrent and phase removal
    frsel_restart_timer #(
        .RESTART    (RESTART)
    ) u_oc_timer (
        .sys_clk    (sys_clk),
        .rst_n      (rst_n),
        .clk_en     (clk_en),
        .fault      (oc_cond),
        .hiccup     (oc2_resp == RESP_HICCUP),
        .latch      (oc2_resp == RESP_LATCH),
        .release_in (release_pwm),
        .stop       (oc_stop)
    );

    // bus output overvoltage hiccup or latch-off
    frsel_restart_timer #(
        .RESTART    (RESTART)
    ) u_ov_timer (
        .sys_clk    (sys_clk),
        .rst_n      (rst_n),
        .clk_en     (clk_en),
        .fault      (r.ov_s2),
        .hiccup     (ov_resp == RESP_HICCUP),
        .latch      (ov_resp == RESP_LATCH),
        .release_in (release_pwm),
        .stop       (ov_stop)
    );

    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            r <= '0;
            r.indiv     <= REG_RESET;
            r.bus_volt  <= REG_RESET;
            r.flag_oe_n <= 1'b1;
            r.fail_oe_n <= 1'b1;
            // enable pins idle high; a zero here would fake an enable edge after reset
            {r.en_s1, r.en_s2, r.en_d}          <= 3'h7;
            {r.pwmen_s1, r.pwmen_s2, r.pwmen_d} <= 3'h7;
        end
        else if (clk_en)
            r <= n;
    end

    assign reg_rdata          = r.rdata;
    assign fault_flag_n_out   = r.od_level;
    assign fault_flag_n_oe_n  = r.flag_oe_n;
    assign system_fail_n_out  = r.od_level;
    assign system_fail_n_oe_n = r.fail_oe_n;
    assign pwm_stop           = r.pwm_stop;
    assign flyback_stop       = r.fly_stop;

endmodule : frsel_top

// *** bench/frsel_assertions.sv ***
// port-level checker for frsel_top
// assumes clk_en held high; shadows two control bits from bus writes
`timescale 1ns/1ps
module frsel_assertions
    import frsel_pkg::*;
(
    input wire logic       sys_clk,
    input wire logic       rst_n,
    input wire logic       reg_wr_en,
    input wire logic       reg_rd_en,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic       fet_short_det,
    input wire logic       fault_flag_n_oe_n,
    input wire logic       system_fail_n_oe_n,
    input wire logic       pwm_stop,
    input wire logic       flyback_stop
);
    typedef struct packed {logic ind; logic fly;} frsel_shd_t;
    frsel_shd_t shd;
    frsel_shd_t next_shd;
    always_comb
    begin
        next_shd = shd;
        if (reg_wr_en && reg_addr == ADDR_INDIV_EN)
            next_shd.ind = reg_wdata[7];
        if (reg_wr_en && reg_addr == ADDR_FLYBACK)
            next_shd.fly = reg_wdata[7];
        if (!rst_n)
            next_shd = '0;
    end
    always_ff @(posedge sys_clk)
        shd <= next_shd;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    short_flag_a: assert property ($rose(fet_short_det) |-> ##3 !fault_flag_n_oe_n)
        else $error("flag not pulled after short");
    fail_mode_a: assert property ($fell(system_fail_n_oe_n) |-> !(shd.ind && shd.fly))
        else $error("fail line pulled in flag-only mode");
    fail_stops_a: assert property (!system_fail_n_oe_n |-> flyback_stop && pwm_stop)
        else $error("fail line without switching stop");
    fly_cause_a: assert property ($rose(flyback_stop) |-> $past(fet_short_det, 3))
        else $error("flyback stop without short");
    flag_sticky_a: assert property ($rose(fault_flag_n_oe_n) |-> $past(reg_wr_en) || $past(reg_wr_en, 2))
        else $error("flag released without clear write");
    rdata_hold_a: assert property (!$past(reg_rd_en) |-> $stable(reg_rdata))
        else $error("read data moved without read");
    reserved_zero_a: assert property (reg_rd_en && reg_addr == ADDR_OC_PHASE |=> reg_rdata[2:0] == 3'h0)
        else $error("reserved bits read nonzero");
    reset_idle_a: assert property ($rose(rst_n) |-> fault_flag_n_oe_n && !pwm_stop && reg_rdata == 8'h00)
        else $error("outputs not idle after reset");
    cover property (!system_fail_n_oe_n);
    cover property ($fell(pwm_stop));
    cover property (!fault_flag_n_oe_n && system_fail_n_oe_n && !pwm_stop);
endmodule : frsel_assertions

bind frsel_top frsel_assertions frsel_assertions_i (.sys_clk, .rst_n, .reg_wr_en, .reg_rd_en,
    .reg_addr, .reg_wdata, .reg_rdata, .fet_short_det, .fault_flag_n_oe_n,
    .system_fail_n_oe_n, .pwm_stop, .flyback_stop);

// *** bench/frsel_seq_model.sv ***
// enable-pin sequencer standing in for the power stage controller
// a one-cycle kick drops its pin for four cycles, then raises it
`timescale 1ns/1ps
module frsel_seq_model
(
    input  wire logic sys_clk,
    input  wire logic kick_en,
    input  wire logic kick_pwm,
    output logic      en_in,
    output logic      pwm_en_in
);
    int   cnt     = 0;
    logic en_low  = 1'b0;
    logic pwm_low = 1'b0;
    always @(posedge sys_clk)
    begin
        if (kick_en)
            en_low <= 1'b1;
        if (kick_pwm)
            pwm_low <= 1'b1;
        if (cnt == 1)
        begin
            en_low <= 1'b0;
            pwm_low <= 1'b0;
        end
        cnt <= (kick_en || kick_pwm) ? 4 : (cnt > 0 ? cnt - 1 : 0);
    end
    // one driver per pin; both idle high
    assign en_in     = !en_low;
    assign pwm_en_in = !pwm_low;
endmodule : frsel_seq_model

// *** bench/fault_response_select_bench.sv ***
// self-checking bench for frsel_top with the sequencer model
// short restart count; pins = {flag out, fail out, fail oe_n, flag oe_n, flyback stop, pwm stop}
`timescale 1ns/1ps
module fault_response_select_bench;
    import frsel_pkg::*;
    localparam int RST = 20;
    logic sys_clk = 1'b0, rst_n = 1'b0, reg_wr_en = 1'b0, reg_rd_en = 1'b0, rd_q = 1'b0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, v;
    logic fet_short_det = 1'b0, lvb_out_ov_det = 1'b0, kick_en = 1'b0, kick_pwm = 1'b0;
    logic clk_en = 1'b1;
    logic fault_flag_n_out, system_fail_n_out;
    logic [3:0] oc2_det = 4'h0;
    logic [1:0] strap_resp = 2'h2;
    logic en_in, pwm_en_in, fault_flag_n_oe_n, system_fail_n_oe_n, pwm_stop, flyback_stop;
    logic [7:0] exp_q[$];
    int mismatches = 0, checks_done = 0;
    integer seed = 32'hE954DA0B;
    wire logic [7:0] pins = {2'h0, fault_flag_n_out, system_fail_n_out, system_fail_n_oe_n,
        fault_flag_n_oe_n, flyback_stop, pwm_stop};
    always #20 sys_clk = ~sys_clk;
    frsel_top #(.RESTART(RST)) frsel_top_i (.sys_clk, .rst_n, .clk_en, .reg_wr_en,
        .reg_rd_en, .reg_addr, .reg_wdata, .reg_rdata, .fet_short_det, .oc2_det,
        .lvb_out_ov_det, .en_in, .pwm_en_in, .strap_resp, .fault_flag_n_out,
        .fault_flag_n_oe_n, .system_fail_n_out, .system_fail_n_oe_n, .pwm_stop, .flyback_stop);
    frsel_seq_model frsel_seq_model_i (.sys_clk, .kick_en, .kick_pwm, .en_in, .pwm_en_in);
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : end_of_test
    task automatic step(input int n);
        repeat (n) @(negedge sys_clk);
    endtask : step
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge sys_clk);
        {reg_wr_en, reg_addr, reg_wdata} = {1'b1, a, d};
        @(negedge sys_clk);
        reg_wr_en = 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(negedge sys_clk);
        {reg_rd_en, reg_addr} = {1'b1, a};
        exp_q.push_back(e);
        @(negedge sys_clk);
        reg_rd_en = 1'b0;
    endtask : rd
    task automatic kick(input logic e);
        @(negedge sys_clk);
        {kick_en, kick_pwm} = {e, !e};
        @(negedge sys_clk);
        {kick_en, kick_pwm} = 2'h0;
        step(12);
    endtask : kick
    // write-1-to-clear every status register, then let the flag settle
    task automatic clr();
        wr(ADDR_ST_CURRENT, 8'hFF);
        wr(ADDR_ST_PHASE, 8'h0F);
        wr(ADDR_ST_BUSV, 8'hFF);
        wr(ADDR_ST_FLYBACK, 8'hFF);
        step(3);
        check("pins idle", pins, 8'h0C);
    endtask : clr
    // read data compared one cycle after each taken read
    always @(posedge sys_clk)
        rd_q <= reg_rd_en;
    always @(negedge sys_clk)
        if (rd_q)
            check("reg_rdata", reg_rdata, exp_q.pop_front());
    initial
    begin
        repeat (3000) @(posedge sys_clk);
        mismatches++;
        end_of_test();
    end
    initial
    begin
        step(20);
        rst_n = 1'b1;
        rd(ADDR_OC_PHASE, 8'h00);
        rd(ADDR_BUS_VOLT, 8'h00);
        v = 8'($random(seed));
        wr(ADDR_BUS_VOLT, v);
        rd(ADDR_BUS_VOLT, v);
        wr(ADDR_OC_PHASE, 8'hFF);
        rd(ADDR_OC_PHASE, 8'hF8);
        rd(8'h00, 8'h00);
        wr(ADDR_INDIV_EN, 8'h80);
        // frozen core must not see the detector until enabled again
        clk_en = 1'b0;
        oc2_det = 4'h2;
        step(6);
        check("pins frozen", pins, 8'h0C);
        clk_en = 1'b1;
        step(6);
        check("pins thawed", pins, 8'h08);
        oc2_det = 4'h0;
        rd(ADDR_ST_PHASE, 8'h02);
        clr();
        for (int c = 0; c < 4; c += 3)
        begin
            wr(ADDR_OC_PHASE, 8'(c << 6));
            v = 8'($random(seed)) & 8'h0F | 8'h01;
            oc2_det = v[3:0];
            step(6);
            check("pins oc2 flag", pins, 8'h08);
            oc2_det = 4'h0;
            step(6);
            check("pins sticky", pins, 8'h08);
            rd(ADDR_ST_PHASE, v);
            rd(ADDR_ST_CURRENT, 8'h02);
            clr();
        end
        for (int s = 0; s < 2; s++)
            for (int m = 1; m < 3; m++)
            begin
                wr(ADDR_OC_PHASE, s ? 8'h00 : 8'(m << 6));
                wr(ADDR_BUS_VOLT, s ? 8'(m) : 8'h00);
                {lvb_out_ov_det, oc2_det} = s ? 5'h10 : 5'h04;
                step(6);
                check("pins stop", pins, 8'h09);
                {lvb_out_ov_det, oc2_det} = 5'h00;
                step(10);
                check("pins still", pins, 8'h09);
                step(20);
                check("pins restart", pins, m == 2 ? 8'h09 : 8'h08);
                if (m == 2)
                    kick(s[0]);
                check("pins resume", pins, 8'h08);
                clr();
            end
        wr(ADDR_BUS_VOLT, 8'h00);
        wr(ADDR_OC_PHASE, 8'h80);
        wr(ADDR_PHASE_DIS, 8'h0F);
        step(8);
        check("pins no removal", pins, 8'h0C);
        // drop to two disabled phases before arming removal, else it trips at once
        wr(ADDR_PHASE_DIS, 8'h03);
        wr(ADDR_OC_PHASE, 8'hA0);
        step(8);
        check("pins half", pins, 8'h0C);
        wr(ADDR_PHASE_DIS, 8'h07);
        step(8);
        check("pins removal", pins, 8'h0D);
        wr(ADDR_PHASE_DIS, 8'h00);
        kick(1'b0);
        check("pins removal released", pins, 8'h0C);
        wr(ADDR_OC_PHASE, 8'h00);
        for (int b = 0; b < 3; b++)
        begin
            wr(ADDR_INDIV_EN, b == 2 ? 8'h00 : 8'h80);
            wr(ADDR_FLYBACK, b == 0 ? 8'h00 : 8'h80);
            fet_short_det = 1'b1;
            step(6);
            fet_short_det = 1'b0;
            step(6);
            check("pins short", pins, b == 1 ? 8'h08 : 8'h03);
            kick(1'b1);
            rd(ADDR_ST_FLYBACK, 8'h10);
            check("pins after en", pins, 8'h08);
            clr();
        end
        oc2_det = 4'h1;
        step(6);
        oc2_det = 4'h0;
        step(30);
        check("pins strap latch", pins, 8'h09);
        kick(1'b0);
        clr();
        wr(ADDR_INDIV_EN, 8'h80);
        rst_n = 1'b0;
        step(3);
        rst_n = 1'b1;
        rd(ADDR_INDIV_EN, 8'h00);
        rd(ADDR_FLYBACK, 8'h00);
        check("pins after reset", pins, 8'h0C);
        end_of_test();
    end
endmodule : fault_response_select_bench
